// ---- mmdf_pkg.sv ----
// Summary of operation
// - contact-input registers read 0 when input off, 1 when on.
// - identifier register returns a fixed read-only product code.
// - firmware version is three registers, two hex digits each.
// - health bit 16 battery over two years; bit 15 default configuration.
// - health bit 14 site-monitor alarm; bit 13 external status input.
// - health bits 12 to 9 show threshold alarms 1 to 4.
// - health bits 3..1 show phase C, B, A voltage; 8..4 reserved.
// - transformer ratios read as ratio times one thousand, 32-bit long.
// - power unit registers return exponent 0, 3, 6 or 9.
// - volt and amp unit registers return exponent 0, 3 or 6.
// - connection type reads 30 for delta, 40 for wye.
// - demand method bit 0 sliding, bit 1 external sync, rest zero.
// - demand interval and subinterval report length in minutes.
// - display list counts at most fifty; profile channels at most twelve.
// - single-register integers are signed 16-bit two's complement.
// - long spans two registers, high word first, low word second.
// - timestamp spans three registers of month/day, year/hour, min/sec.
// - decimal triple is three 0-9999 groups, least significant first.
// - each display item has a format-type field naming its encoding.
// - log record is timestamp then 1-12 channels of count, weight, exp.
// - registers are served to the master through read function 03.
`default_nettype none
package mmdf_pkg;
   // register numbers as printed
   localparam logic [15:0] ADDR_CONTACT_ONE   = 16'h0578;
   localparam logic [15:0] ADDR_CONTACT_TWO   = 16'h0579;
   localparam logic [15:0] ADDR_METER_IDENTIFIER      = 16'h06A4;
   localparam logic [15:0] ADDR_FW_VERSION    = 16'h06A9;
   localparam logic [15:0] ADDR_HEALTH        = 16'h06AD;
   localparam logic [15:0] ADDR_VOLT_XFMR     = 16'h06AE;
   localparam logic [15:0] ADDR_AMP_XFMR      = 16'h06B0;
   localparam logic [15:0] ADDR_REAL_UNIT     = 16'h06B2;
   localparam logic [15:0] ADDR_REACT_UNIT    = 16'h06B3;
   localparam logic [15:0] ADDR_VOLT_UNIT     = 16'h06B4;
   localparam logic [15:0] ADDR_AMP_UNIT      = 16'h06B5;
   localparam logic [15:0] ADDR_VOLT2_UNIT    = 16'h06B6;
   localparam logic [15:0] ADDR_AMP2_UNIT     = 16'h06B7;
   localparam logic [15:0] ADDR_WIRING        = 16'h06B8;
   localparam logic [15:0] ADDR_DEMAND_METHOD = 16'h06B9;
   localparam logic [15:0] ADDR_DEMAND_INT    = 16'h06BA;
   localparam logic [15:0] ADDR_DEMAND_SUB    = 16'h06BB;
   localparam logic [15:0] ADDR_NORMAL_CNT    = 16'h06BC;
   localparam logic [15:0] ADDR_ALT_CNT       = 16'h06BD;
   localparam logic [15:0] ADDR_INTERNAL_CNT  = 16'h06BE;
   localparam logic [15:0] ADDR_PROFILE_CNT   = 16'h06BF;
   // function code and exception codes
   localparam logic [7:0]  FUNC_READ_HOLDING  = 8'h03;
   localparam logic [7:0]  EXC_ILLEGAL_FUNC   = 8'h01;
   localparam logic [7:0]  EXC_ILLEGAL_ADDR   = 8'h02;
   localparam logic [7:0]  EXC_ILLEGAL_VALUE  = 8'h03;
   localparam logic [7:0]  MAX_READ_COUNT     = 8'h7D;
   // health bit positions (bit n counted from 1 is index n-1)
   localparam int HB_BATTERY   = 15;
   localparam int HB_CFG_ERR   = 14;
   localparam int HB_SITE_MON  = 13;
   localparam int HB_EXT_IN    = 12;
   localparam int HB_THRESH_LO = 8;
   localparam int HB_PHASE_LO  = 0;
   // battery warning: two years of cumulative seconds
   localparam logic [31:0] BATTERY_LIMIT_S    = 32'h03C2_6700;
   localparam real         CLK_MHZ            = 125.0;
   localparam int          TICKS_PER_SEC      = int'(CLK_MHZ * 1.0e6);
   localparam logic [31:0] RATIO_SCALE        = 32'h0000_03E8;
   // legal codes
   localparam logic [15:0] EXP_BASE  = 16'h0000;
   localparam logic [15:0] EXP_KILO  = 16'h0003;
   localparam logic [15:0] EXP_MEGA  = 16'h0006;
   localparam logic [15:0] EXP_GIGA  = 16'h0009;
   localparam logic [15:0] WIRE_DELTA = 16'h001E;
   localparam logic [15:0] WIRE_WYE   = 16'h0028;
   localparam logic [15:0] MAX_DISPLAY = 16'h0032;
   localparam logic [15:0] MAX_CHANNELS = 16'h000C;
   localparam logic [15:0] DEC_GROUP_MAX = 16'h270F;
   localparam int DM_SLIDING = 0;
   localparam int DM_EXT_SYNC = 1;
   // display format types
   typedef enum logic [1:0] {
      MMDF_FMT_SCALED_LONG   = 2'b00,
      MMDF_FMT_SCALED_TRIPLE = 2'b01,
      MMDF_FMT_PLAIN_LONG    = 2'b10,
      MMDF_FMT_TIME          = 2'b11
   } mmdf_fmt_t;
   // timestamp as three words, upper byte first in each
   typedef struct packed {
      logic [7:0] month, day;
      logic [7:0] year, hour;
      logic [7:0] minute, second;
   } mmdf_time_t;
   // twelve digits as three 0..9999 groups; element 0 is sent first
   typedef logic [2:0][15:0] mmdf_decimal_triple_t;
   // log channel: count times weight times ten to the exponent
   typedef struct packed {
      logic [15:0] pulseCount;
      logic [15:0] pulseWeight;
      logic [15:0] tenPower;
   } mmdf_interval_log_chan_t;
   // configuration from the meter core
   typedef struct packed {
      logic [47:0] fwVersion;
      logic [31:0] voltXfmrRatio;
      logic [31:0] ampXfmrRatio;
      logic [15:0] realUnit;
      logic [15:0] reactUnit;
      logic [15:0] voltUnit;
      logic [15:0] ampUnit;
      logic [15:0] volt2Unit;
      logic [15:0] amp2Unit;
      logic        wyeService;
      logic        slidingWindow;
      logic        externalSync;
      logic [15:0] demandMinutes;
      logic [15:0] subMinutes;
      logic [15:0] normalCount;
      logic [15:0] altCount;
      logic [15:0] internalCount;
      logic [15:0] channelCount;
      logic        configError;
   } mmdf_cfg_t;
   // live status from the meter core
   typedef struct packed {
      logic [1:0] contactIn;
      logic       siteAlarm;
      logic       extStatus;
      logic [3:0] thresholdAlarm;
      logic [2:0] phaseActive;
      logic       onBattery;
   } mmdf_stat_t;
   // read request and answer
   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] start;
      logic [7:0]  count;
   } mmdf_req_t;
   typedef struct packed {
      logic        exception;
      logic [7:0]  code;
      logic [15:0] data;
      logic        last;
   } mmdf_rsp_t;
endpackage : mmdf_pkg
`default_nettype wire

// ---- mmdf_reg_bank.sv ----
`default_nettype none
module mmdf_reg_bank #(
   parameter logic [15:0] METER_IDENTIFIER_CODE = 16'h1234, // arbitrary value
   parameter logic [31:0] BATTERY_LIMIT = mmdf_pkg::BATTERY_LIMIT_S,
   parameter int          SEC_TICKS     = mmdf_pkg::TICKS_PER_SEC
) (
   input  wire logic               clk,       // 125 MHz system clock
   input  wire logic               sys_rst,   // async reset, active high
   input  wire mmdf_pkg::mmdf_cfg_t cfgIn,    // configured meter settings
   input  wire mmdf_pkg::mmdf_stat_t statIn,  // live status levels
   input  wire logic               cfgUpdate, // pulse outside MMDF_SEND: take a new snapshot
   input  wire logic               reqValid,  // read request present
   output logic                    reqReady,  // request accepted
   input  wire mmdf_pkg::mmdf_req_t reqIn,    // function, start, count
   output logic                    rspValid,  // answer word present
   input  wire logic               rspReady,  // master takes answer word
   output mmdf_pkg::mmdf_rsp_t     rspOut     // answer word or exception
);
   typedef enum logic [1:0] {
      MMDF_IDLE = 2'b00,
      MMDF_SEND = 2'b01,
      MMDF_EXC  = 2'b10
   } mmdf_state_t;

   mmdf_state_t          state_reg;
   mmdf_pkg::mmdf_cfg_t  snap_reg;
   mmdf_pkg::mmdf_stat_t live_reg;
   logic [15:0]          addr_reg;
   logic [7:0]           left_reg;
   logic [7:0]           code_reg;
   logic [31:0]          tick_reg;
   logic [31:0]          battSec_reg;
   logic                 battWarn_reg;
   logic [15:0]          health;
   logic [15:0]          word;
   logic                 hit;
   logic                 rangeOk;
   logic [16:0]          lastAddr;
   logic [31:0]          voltScaled;
   logic [31:0]          ampScaled;

   // a ratio times one thousand as a long value
   function automatic logic [31:0] scaleRatio(input logic [31:0] r);
      logic [63:0] p;
      p = 64'(r) * 64'(mmdf_pkg::RATIO_SCALE);
      return p[31:0];
   endfunction : scaleRatio

   // keep exponent to allowed codes; unknown reads as base units
   function automatic logic [15:0] clipExp(input logic [15:0] e,
                                           input logic allowGiga);
      logic ok;
      ok = (e == mmdf_pkg::EXP_BASE) || (e == mmdf_pkg::EXP_KILO) ||
           (e == mmdf_pkg::EXP_MEGA) || (allowGiga && e == mmdf_pkg::EXP_GIGA);
      return ok ? e : mmdf_pkg::EXP_BASE;
   endfunction : clipExp

   function automatic logic [15:0] clipMax(input logic [15:0] v,
                                           input logic [15:0] m);
      return (v > m) ? m : v;
   endfunction : clipMax

   // ratios scaled once, then split into high and low words
   assign voltScaled = scaleRatio(snap_reg.voltXfmrRatio);
   assign ampScaled  = scaleRatio(snap_reg.ampXfmrRatio);

   // coherent snapshot so a long never mixes two update instants
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         snap_reg <= '0;
      end else if (cfgUpdate && state_reg != MMDF_SEND) begin
         snap_reg <= cfgIn;
      end
   end

   // live levels registered once per cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         live_reg <= '0;
      end else begin
         live_reg <= statIn;
      end
   end

   // cumulative seconds spent on battery
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_reg    <= 32'h0000_0000;
         battSec_reg <= 32'h0000_0000;
      end else if (live_reg.onBattery) begin
         if (tick_reg == 32'(SEC_TICKS - 1)) begin
            tick_reg <= 32'h0000_0000;
            if (battSec_reg != 32'hFFFF_FFFF) begin
               battSec_reg <= battSec_reg + 32'h0000_0001;
            end
         end else begin
            tick_reg <= tick_reg + 32'h0000_0001;
         end
      end
   end

   // warning sticks once the limit is passed
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         battWarn_reg <= 1'b0;
      end else if (battSec_reg > BATTERY_LIMIT) begin
         battWarn_reg <= 1'b1;
      end
   end

   // health word, reserved bits 8..4 read zero
   always_comb begin
      health = 16'h0000;
      health[mmdf_pkg::HB_BATTERY] = battWarn_reg;
      health[mmdf_pkg::HB_CFG_ERR] = snap_reg.configError;
      health[mmdf_pkg::HB_SITE_MON] = live_reg.siteAlarm;
      health[mmdf_pkg::HB_EXT_IN] = live_reg.extStatus;
      // alarm 1 lands on bit 12, alarm 4 on bit 9
      for (int i = 0; i < 4; i++) begin
         health[mmdf_pkg::HB_THRESH_LO + i] =
            live_reg.thresholdAlarm[3 - i];
      end
      for (int i = 0; i < 3; i++) begin
         health[mmdf_pkg::HB_PHASE_LO + i] = live_reg.phaseActive[i];
      end
   end

   // word mux: unmapped numbers clear hit
   always_comb begin
      word = 16'h0000;
      hit  = 1'b1;
      unique case (addr_reg)
         mmdf_pkg::ADDR_CONTACT_ONE:
            word = {15'h0000, live_reg.contactIn[0]};
         mmdf_pkg::ADDR_CONTACT_TWO:
            word = {15'h0000, live_reg.contactIn[1]};
         mmdf_pkg::ADDR_METER_IDENTIFIER:
            word = METER_IDENTIFIER_CODE;
         mmdf_pkg::ADDR_FW_VERSION:
            word = snap_reg.fwVersion[47:32];
         mmdf_pkg::ADDR_FW_VERSION + 16'h0001:
            word = snap_reg.fwVersion[31:16];
         mmdf_pkg::ADDR_FW_VERSION + 16'h0002:
            word = snap_reg.fwVersion[15:0];
         mmdf_pkg::ADDR_HEALTH:
            word = health;
         // high word first, then low word
         mmdf_pkg::ADDR_VOLT_XFMR:
            word = voltScaled[31:16];
         mmdf_pkg::ADDR_VOLT_XFMR + 16'h0001:
            word = voltScaled[15:0];
         mmdf_pkg::ADDR_AMP_XFMR:
            word = ampScaled[31:16];
         mmdf_pkg::ADDR_AMP_XFMR + 16'h0001:
            word = ampScaled[15:0];
         mmdf_pkg::ADDR_REAL_UNIT:
            word = clipExp(snap_reg.realUnit, 1'b1);
         mmdf_pkg::ADDR_REACT_UNIT:
            word = clipExp(snap_reg.reactUnit, 1'b1);
         mmdf_pkg::ADDR_VOLT_UNIT:
            word = clipExp(snap_reg.voltUnit, 1'b0);
         mmdf_pkg::ADDR_AMP_UNIT:
            word = clipExp(snap_reg.ampUnit, 1'b0);
         mmdf_pkg::ADDR_VOLT2_UNIT:
            word = clipExp(snap_reg.volt2Unit, 1'b0);
         mmdf_pkg::ADDR_AMP2_UNIT:
            word = clipExp(snap_reg.amp2Unit, 1'b0);
         mmdf_pkg::ADDR_WIRING:
            word = snap_reg.wyeService ? mmdf_pkg::WIRE_WYE
                                       : mmdf_pkg::WIRE_DELTA;
         mmdf_pkg::ADDR_DEMAND_METHOD: begin
            word[mmdf_pkg::DM_SLIDING]  = snap_reg.slidingWindow;
            word[mmdf_pkg::DM_EXT_SYNC] = snap_reg.externalSync;
         end
         mmdf_pkg::ADDR_DEMAND_INT:
            word = snap_reg.demandMinutes;
         mmdf_pkg::ADDR_DEMAND_SUB:
            word = snap_reg.subMinutes;
         mmdf_pkg::ADDR_NORMAL_CNT:
            word = clipMax(snap_reg.normalCount,
                           mmdf_pkg::MAX_DISPLAY);
         mmdf_pkg::ADDR_ALT_CNT:
            word = clipMax(snap_reg.altCount, mmdf_pkg::MAX_DISPLAY);
         mmdf_pkg::ADDR_INTERNAL_CNT:
            word = clipMax(snap_reg.internalCount,
                           mmdf_pkg::MAX_DISPLAY);
         mmdf_pkg::ADDR_PROFILE_CNT:
            word = clipMax(snap_reg.channelCount,
                           mmdf_pkg::MAX_CHANNELS);
         default:
            hit = 1'b0;
      endcase
   end

   // whole requested range must sit in mapped words; checked via walk
   assign lastAddr = 17'(reqIn.start) + 17'(reqIn.count) - 17'h00001;
   assign rangeOk  = (reqIn.count != 8'h00) &&
                     (reqIn.count <= mmdf_pkg::MAX_READ_COUNT) &&
                     !lastAddr[16];

   assign reqReady = (state_reg == MMDF_IDLE);

   // request walk; only function 03 is served
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= MMDF_IDLE;
         addr_reg  <= 16'h0000;
         left_reg  <= 8'h00;
         code_reg  <= 8'h00;
      end else begin
         unique case (state_reg)
            MMDF_IDLE: if (reqValid) begin
               addr_reg <= reqIn.start;
               left_reg <= reqIn.count;
               if (reqIn.func != mmdf_pkg::FUNC_READ_HOLDING) begin
                  code_reg  <= mmdf_pkg::EXC_ILLEGAL_FUNC;
                  state_reg <= MMDF_EXC;
               end else if (!rangeOk) begin
                  code_reg  <= mmdf_pkg::EXC_ILLEGAL_VALUE;
                  state_reg <= MMDF_EXC;
               end else begin
                  state_reg <= MMDF_SEND;
               end
            end
            MMDF_SEND: if (rspReady) begin
               addr_reg <= addr_reg + 16'h0001;
               left_reg <= left_reg - 8'h01;
               // an unmapped word is answered by the exception itself
               if (!hit || left_reg == 8'h01) begin
                  state_reg <= MMDF_IDLE;
               end
            end
            MMDF_EXC: if (rspReady) begin
               state_reg <= MMDF_IDLE;
            end
            default: state_reg <= MMDF_IDLE;
         endcase
      end
   end

   // answer: words while sending; an unmapped word is answered at once by
   // the exception, so no answer ever comes later than one cycle
   assign rspValid = (state_reg == MMDF_EXC) || (state_reg == MMDF_SEND);
   assign rspOut.exception = (state_reg == MMDF_EXC) ||
                             (state_reg == MMDF_SEND && !hit);
   assign rspOut.code      = (state_reg == MMDF_EXC) ? code_reg :
                             !hit ? mmdf_pkg::EXC_ILLEGAL_ADDR :
                             mmdf_pkg::FUNC_READ_HOLDING;
   assign rspOut.data      = (state_reg == MMDF_SEND) ? word : 16'h0000;
   assign rspOut.last      = (state_reg == MMDF_EXC) || !hit ||
                             (left_reg == 8'h01);
endmodule : mmdf_reg_bank
`default_nettype wire

// ---- mmdf_reg_bank_chk.sv ----
`default_nettype none
module mmdf_reg_bank_chk (
   input wire logic                 clk,       // system clock
   input wire logic                 sys_rst,   // async reset, active high
   input wire logic                 reqValid,  // request present
   input wire logic                 reqReady,  // request accepted
   input wire mmdf_pkg::mmdf_req_t  reqIn,     // request fields
   input wire logic                 rspValid,  // answer word present
   input wire logic                 rspReady,  // master takes word
   input wire mmdf_pkg::mmdf_rsp_t  rspOut     // answer word
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // request taken, and taken as a holding read
   logic taken;
   logic rd03;
   assign taken = reqValid && reqReady;
   assign rd03  = taken && reqIn.func == 8'h03;

   a_busy_refuse: assert property (rspValid |-> !reqReady)
      else $error("request accepted during an answer");
   a_answer_next: assert property (taken |=> rspValid)
      else $error("no answer one cycle after request");
   a_rsp_hold: assert property (rspValid && !rspReady |=>
      rspValid && $stable(rspOut))
      else $error("answer word moved while stalled");
   a_bad_func: assert property (taken && reqIn.func != 8'h03 |=>
      rspOut.exception && rspOut.code == 8'h01)
      else $error("wrong function not refused");
   a_bad_count: assert property (rd03 && (reqIn.count == 8'h00 ||
      reqIn.count > 8'h7D) |=> rspOut.exception && rspOut.code == 8'h03)
      else $error("bad count not refused");
   a_data_code: assert property (rspValid && !rspOut.exception |->
      rspOut.code == 8'h03)
      else $error("data word without function code");
   a_idle_after: assert property (rspValid && rspReady &&
      (rspOut.last || rspOut.exception) |=> reqReady)
      else $error("not ready after final word");
   a_wiring_code: assert property (rd03 && reqIn.count == 8'h01 &&
      reqIn.start == mmdf_pkg::ADDR_WIRING |=>
      rspOut.data == 16'h001E || rspOut.data == 16'h0028)
      else $error("wiring type neither delta nor wye");
   a_health_resv: assert property (rd03 && reqIn.count == 8'h01 &&
      reqIn.start == mmdf_pkg::ADDR_HEALTH |=> rspOut.data[7:3] == 5'h00)
      else $error("reserved health bits set");

   // main traffic shapes
   c_multi: cover property (taken && reqIn.count > 8'h01);
   c_stall: cover property (rspValid && !rspReady);
   c_unmapped: cover property (rspValid && rspOut.code == 8'h02);
endmodule : mmdf_reg_bank_chk

bind mmdf_reg_bank mmdf_reg_bank_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .reqValid(reqValid), .reqReady(reqReady), .reqIn(reqIn),
   .rspValid(rspValid), .rspReady(rspReady), .rspOut(rspOut));
`default_nettype wire

// ---- mmdf_master_model.sv ----
`default_nettype none
module mmdf_master_model (
   input  wire logic                clk,      // system clock
   input  wire logic                reqReady, // bank takes a request
   input  wire logic                rspValid, // answer word present
   input  wire mmdf_pkg::mmdf_rsp_t rspOut,   // answer word
   output var  logic                reqValid, // request present
   output var  mmdf_pkg::mmdf_req_t reqIn,    // request fields
   output var  logic                rspReady  // taking answer words
);
   timeunit 1ns;
   timeprecision 1ps;
   mmdf_pkg::mmdf_rsp_t words[$]; // words of the last read
   logic slow = 1'b0;             // stall every other cycle
   initial begin
      reqValid = 1'b0;
      reqIn    = '0;
      rspReady = 1'b0;
   end
   // one holding read; fields stand until the taking edge
   task automatic rd(input logic [7:0] f, input logic [15:0] s,
                     input logic [7:0] c);
      words.delete();
      @(negedge clk);
      reqIn    = '{func: f, start: s, count: c};
      reqValid = 1'b1;
      do @(posedge clk); while (!reqReady);
      @(negedge clk);
      reqValid = 1'b0;
      reqIn    = ~reqIn; // released fields must not look valid
      for (int n = 0; n < 400; n++) begin
         rspReady = !(slow && n[0]);
         @(posedge clk);
         if (rspValid && rspReady) begin
            words.push_back(rspOut);
            if (rspOut.last || rspOut.exception) break;
         end
         @(negedge clk);
      end
      @(negedge clk);
      rspReady = 1'b0;
   endtask : rd
endmodule : mmdf_master_model
`default_nettype wire

// ---- mmdf_tb.sv ----
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ID_CODE = 16'h5A3C; // arbitrary value
   logic                 clk;
   logic                 sys_rst;
   mmdf_pkg::mmdf_cfg_t  cfgIn;
   mmdf_pkg::mmdf_stat_t statIn;
   logic                 cfgUpdate;
   logic                 reqValid;
   logic                 reqReady;
   mmdf_pkg::mmdf_req_t  reqIn;
   logic                 rspValid;
   logic                 rspReady;
   mmdf_pkg::mmdf_rsp_t  rspOut;
   int                   nFail = 0;
   int                   samplesChecked = 0;
   int                   cycles = 0;

   // short battery limit: 3 seconds of 4 cycles each
   mmdf_reg_bank #(.METER_IDENTIFIER_CODE(ID_CODE), .BATTERY_LIMIT(32'h0000_0003),
      .SEC_TICKS(4)) u_dut (.clk(clk), .sys_rst(sys_rst), .cfgIn(cfgIn),
      .statIn(statIn), .cfgUpdate(cfgUpdate), .reqValid(reqValid),
      .reqReady(reqReady), .reqIn(reqIn), .rspValid(rspValid),
      .rspReady(rspReady), .rspOut(rspOut));
   mmdf_master_model u_mst (.clk(clk), .reqReady(reqReady),
      .rspValid(rspValid), .rspOut(rspOut), .reqValid(reqValid),
      .reqIn(reqIn), .rspReady(rspReady));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         nFail++;
         $display("Error timeout expected %0d seen %0d", 19999, cycles);
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] e, g);
      samplesChecked++;
      if (g !== e) begin
         nFail++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // data word i must be a plain answer carrying e
   task automatic wd(input int i, input logic [15:0] e);
      chk("word", {16'h0000, e}, {15'h0000, u_mst.words[i].exception,
          u_mst.words[i].data});
   endtask : wd

   task automatic load(input mmdf_pkg::mmdf_cfg_t c);
      @(negedge clk);
      cfgIn     = c;
      cfgUpdate = 1'b1;
      @(negedge clk);
      cfgUpdate = 1'b0;
   endtask : load

   task automatic t_reset();
      u_mst.rd(8'h03, mmdf_pkg::ADDR_WIRING, 8'h01);
      wd(0, 16'h001E);
      u_mst.rd(8'h03, mmdf_pkg::ADDR_REAL_UNIT, 8'h06);
      for (int i = 0; i < 6; i++) wd(i, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   // alt: giga power, bad amp code, normal and profile counts over the limits
   task automatic t_config(input logic alt);
      mmdf_pkg::mmdf_cfg_t c;
      logic [31:0] v;
      logic [31:0] w;
      logic [15:0] e[18];
      c = '0;
      c.fwVersion = alt ? 48'h00B3_0000_0012 : 48'h0001_0099_0020;
      c.voltXfmrRatio = alt ? 32'h0001_1170 : 32'h0000_0001;
      c.ampXfmrRatio = alt ? 32'h0000_0005 : 32'h001E_8480;
      {c.realUnit, c.reactUnit, c.voltUnit, c.ampUnit, c.volt2Unit,
       c.amp2Unit} = alt ? 96'h0009_0006_0003_0009_0006_0000
                         : 96'h0000_0003_0006_0003_0000_0003;
      c.wyeService = alt;
      c.slidingWindow = alt;
      c.externalSync = !alt;
      c.demandMinutes = alt ? 16'h000F : 16'h001E;
      c.subMinutes = alt ? 16'h0005 : 16'h000A;
      c.normalCount = alt ? 16'h003C : 16'h0032;
      c.altCount = alt ? 16'h0000 : 16'h0001;
      c.internalCount = alt ? 16'h0031 : 16'h0032;
      c.channelCount = alt ? 16'h000D : 16'h000C;
      c.configError = alt;
      v = c.voltXfmrRatio * mmdf_pkg::RATIO_SCALE;
      w = c.ampXfmrRatio * mmdf_pkg::RATIO_SCALE;
      e = '{v[31:16], v[15:0], w[31:16], w[15:0], c.realUnit, c.reactUnit,
            c.voltUnit, alt ? 16'h0000 : c.ampUnit, c.volt2Unit, c.amp2Unit,
            alt ? 16'h0028 : 16'h001E, {14'h0000, c.externalSync,
            c.slidingWindow}, c.demandMinutes, c.subMinutes, 16'h0032,
            c.altCount, c.internalCount, 16'h000C};
      load(c);
      u_mst.rd(8'h03, mmdf_pkg::ADDR_VOLT_XFMR, 8'h12);
      chk("count", 32'h0000_0012, 32'(u_mst.words.size()));
      for (int i = 0; i < 4; i++) wd(i, e[i]);
      for (int i = 4; i < 10; i++) wd(i, e[i]);
      wd(10, e[10]);
      wd(11, e[11]);
      for (int i = 12; i < 14; i++) wd(i, e[i]);
      for (int i = 14; i < 18; i++) wd(i, e[i]);
      u_mst.rd(8'h03, mmdf_pkg::ADDR_FW_VERSION, 8'h03);
      for (int i = 0; i < 3; i++) wd(i, c.fwVersion[47-16*i -: 16]);
      u_mst.rd(8'h03, mmdf_pkg::ADDR_METER_IDENTIFIER, 8'h01);
      wd(0, ID_CODE);
      u_mst.rd(8'h03, mmdf_pkg::ADDR_HEALTH, 8'h01);
      wd(0, {1'b0, alt, 14'h0000});
      $display("test config done");
   endtask : t_config

   // one status level at a time
   task automatic t_status();
      logic [15:0] h;
      for (int i = 1; i < 12; i++) begin
         @(negedge clk);
         statIn = 12'h001 << i;
         h = {2'b00, statIn.siteAlarm, statIn.extStatus,
              statIn.thresholdAlarm[0], statIn.thresholdAlarm[1],
              statIn.thresholdAlarm[2], statIn.thresholdAlarm[3], 5'h00,
              statIn.phaseActive};
         u_mst.rd(8'h03, mmdf_pkg::ADDR_CONTACT_ONE, 8'h02);
         wd(0, {15'h0000, statIn.contactIn[0]});
         wd(1, {15'h0000, statIn.contactIn[1]});
         u_mst.rd(8'h03, mmdf_pkg::ADDR_HEALTH, 8'h01);
         wd(0, h);
      end
      statIn = '0;
      $display("test status done");
   endtask : t_status

   // func, start, count, words expected, final code
   task automatic t_refuse();
      logic [47:0] cs[6];
      mmdf_pkg::mmdf_rsp_t r;
      cs = '{48'h04_06B8_01_01_01, 48'h03_06B8_00_01_03,
             48'h03_06B8_7E_01_03, 48'h03_FFFF_02_01_03,
             48'h03_06AA_03_03_02, 48'h03_06BF_02_02_02};
      u_mst.slow = 1'b1;
      foreach (cs[k]) begin
         u_mst.rd(cs[k][47:40], cs[k][39:24], cs[k][23:16]);
         r = u_mst.words[$];
         chk("count", 32'(cs[k][15:8]), 32'(u_mst.words.size()));
         chk("refusal", {23'h0, 1'b1, cs[k][7:0]},
             {23'h0, r.exception, r.code});
      end
      u_mst.slow = 1'b0;
      $display("test refuse done");
   endtask : t_refuse

   // update pulse during a stalled reply must not tear the long
   task automatic t_snapshot();
      u_mst.slow = 1'b1;
      fork
         u_mst.rd(8'h03, mmdf_pkg::ADDR_VOLT_XFMR, 8'h02);
         begin
            repeat (2) @(negedge clk);
            cfgIn.voltXfmrRatio = 32'h0000_0009;
            cfgUpdate = 1'b1;
            @(negedge clk);
            cfgUpdate = 1'b0;
         end
      join
      u_mst.slow = 1'b0;
      wd(1, 16'h03E8);
      u_mst.rd(8'h03, mmdf_pkg::ADDR_VOLT_XFMR, 8'h02);
      wd(1, 16'h03E8);
      load(cfgIn);
      u_mst.rd(8'h03, mmdf_pkg::ADDR_VOLT_XFMR, 8'h02);
      wd(1, 16'h2328);
      $display("test snapshot done");
   endtask : t_snapshot

   // 2 s on battery stays quiet, 7 s total sets a sticky flag
   task automatic t_battery();
      @(negedge clk);
      statIn.onBattery = 1'b1;
      repeat (8) @(negedge clk);
      statIn.onBattery = 1'b0;
      u_mst.rd(8'h03, mmdf_pkg::ADDR_HEALTH, 8'h01);
      wd(0, 16'h0000);
      statIn.onBattery = 1'b1;
      repeat (20) @(negedge clk);
      statIn.onBattery = 1'b0;
      u_mst.rd(8'h03, mmdf_pkg::ADDR_HEALTH, 8'h01);
      wd(0, 16'h8000);
      $display("test battery done");
   endtask : t_battery

   initial begin
      sys_rst = 1'b1;
      cfgIn = '0;
      statIn = '0;
      cfgUpdate = 1'b0;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      t_reset();
      t_config(1'b1);
      t_config(1'b0);
      t_status();
      t_refuse();
      t_snapshot();
      t_battery();
      test_done();
   end
endmodule : tb
`default_nettype wire
